// ===== verilog/vei_pkg.sv
package vei_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TAG = 4'h4;
  localparam logic [3:0] ADDR_SAVED = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hC;
  localparam logic [31:0] RST_CTRL = 32'h0000_0040;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************************************************************
  // widths
  // ************************************************************
  localparam int LVL_W = 6;
  localparam int SS_W = 4;
  localparam int TAG_W = 8;
  localparam int VS_W = 5;
  localparam int NUM_W = 6;
  localparam int OFF_W = 17;
  localparam int VS_SHIFT = 5;
  // ************************************************************
  // register fields
  // ************************************************************
  localparam int CTRL_VS_LSB = 0;
  localparam int CTRL_IV_BIT = 5;
  localparam int CTRL_BEV_BIT = 6;
  localparam int CTRL_PRES_BIT = 7;
  localparam int CTRL_GM_BIT = 8;
  localparam int CTRL_PML_LSB = 10;
  localparam int CTRL_ESS_LSB = 16;
  localparam int TAG_RES_LSB = 0;
  localparam int TAG_EID_LSB = 8;
  localparam int SAV_LVL_LSB = 0;
  localparam int SAV_SS_LSB = 8;
  localparam int SAV_VEC_LSB = 12;
  localparam int STAT_LVL_LSB = 0;
  localparam int STAT_SS_LSB = 6;
  localparam int STAT_ACT_BIT = 10;
  localparam int STAT_EIC_BIT = 11;
  localparam int STAT_VEC_LSB = 12;
  // ************************************************************
  // vectoring
  // ************************************************************
  localparam logic VEC_IS_NUMBER = 1'b1;
  localparam logic [OFF_W-1:0] VEC_BASE = 17'h00200;
endpackage

// ===== verilog/vei_core.sv
`timescale 1ns/1ps
`default_nettype none
module vei_core
  import vei_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [3:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [3:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic [LVL_W-1:0] i_root_rpl,
  input wire logic [OFF_W-1:0] i_root_vector,
  input wire logic [SS_W-1:0] i_root_shadow_set,
  input wire logic [TAG_W-1:0] i_root_vm_tag,
  input wire logic [LVL_W-1:0] i_guest_rpl,
  input wire logic [OFF_W-1:0] i_guest_vector,
  input wire logic [SS_W-1:0] i_guest_shadow_set,
  input wire logic i_exception_return_op,
  input wire logic i_monitor_call_op,
  output logic o_irq_valid,
  output logic o_irq_guest_ctx,
  output logic [OFF_W-1:0] o_vector_offset,
  output logic [SS_W-1:0] o_shadow_set,
  output logic o_root_ack,
  output logic o_guest_ack,
  output logic [TAG_W-1:0] o_resident_vm_tag,
  output logic o_vm_active
);
  // ************************************************************
  // register bus
  // ************************************************************
  logic [3:0] aw_addr_reg;
  logic aw_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_hold_reg;
  logic wr_do;
  logic [31:0] ctrl_reg;
  logic [TAG_W-1:0] resident_vm_tag_reg;
  logic [TAG_W-1:0] interrupt_vm_tag_reg;
  logic [LVL_W-1:0] saved_vm_priority_level_reg;
  logic [SS_W-1:0] saved_vm_shadow_set_reg;
  logic [OFF_W-1:0] saved_vector_reg;
  logic [LVL_W-1:0] guest_req_lvl_reg;
  logic [SS_W-1:0] guest_ss_reg;
  logic vm_active_reg;
  logic inject_pend_reg;
  logic [LVL_W-1:0] root_prev_reg;
  logic [LVL_W-1:0] guest_prev_reg;
  logic [31:0] rd_next;
  logic rd_ok;
  logic [LVL_W-1:0] guest_read_lvl;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign o_awready = !aw_hold_reg && !o_bvalid;
  assign o_wready = !w_hold_reg && !o_bvalid;
  assign o_arready = !o_rvalid;
  assign wr_do = aw_hold_reg && w_hold_reg && !o_bvalid;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      if (wr_do) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (aw_addr_reg == ADDR_STAT || aw_addr_reg[1:0] != 2'h0) ? RESP_SLVERR
                   : RESP_OKAY;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // control fields
  // ************************************************************
  logic [VS_W-1:0] vector_spacing;
  logic vectored_cause_flag;
  logic boot_vector_flag;
  logic ext_controller_present;
  logic vm_mode_select;
  logic [LVL_W-1:0] priority_mask_level;
  logic [SS_W-1:0] exception_shadow_set;
  logic eic_mode;

  assign vector_spacing = ctrl_reg[CTRL_VS_LSB +: VS_W];
  assign vectored_cause_flag = ctrl_reg[CTRL_IV_BIT];
  assign boot_vector_flag = ctrl_reg[CTRL_BEV_BIT];
  assign ext_controller_present = ctrl_reg[CTRL_PRES_BIT];
  assign vm_mode_select = ctrl_reg[CTRL_GM_BIT];
  assign priority_mask_level = ctrl_reg[CTRL_PML_LSB +: LVL_W];
  assign exception_shadow_set = ctrl_reg[CTRL_ESS_LSB +: SS_W];
  assign eic_mode = ext_controller_present && (vector_spacing != '0) && vectored_cause_flag
                    && !boot_vector_flag;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_reg <= RST_CTRL;
      resident_vm_tag_reg <= '0;
    end else if (wr_do) begin
      if (aw_addr_reg == ADDR_CTRL) begin
        ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg);
      end
      if (aw_addr_reg == ADDR_TAG && w_strb_reg[0]) begin
        resident_vm_tag_reg <= w_data_reg[TAG_RES_LSB +: TAG_W];
      end
    end
  end

  // registered copy so the controller sees a clean, settled tag
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_resident_vm_tag <= '0;
    end else begin
      o_resident_vm_tag <= resident_vm_tag_reg;
    end
  end

  // ************************************************************
  // event detection
  // ************************************************************
  function automatic logic [OFF_W-1:0] vec_off(input logic [OFF_W-1:0] v,
                                               input logic tagged_irq,
                                               input logic [VS_W-1:0] vs);
    logic [OFF_W-1:0] r;
    r = VEC_BASE;
    if (!tagged_irq) begin
      if (VEC_IS_NUMBER) begin
        r = OFF_W'(VEC_BASE + v[NUM_W-1:0] * {vs, {VS_SHIFT{1'b0}}});
      end else begin
        r = v;
      end
    end
    return r;
  endfunction

  logic root_chg;
  logic guest_chg;
  logic root_fire;
  logic guest_fire;
  logic inject_fire;
  logic root_tagged;
  logic guest_entry;

  assign root_tagged = i_root_vm_tag != '0;
  assign root_chg = i_root_rpl != root_prev_reg;
  assign guest_chg = i_guest_rpl != guest_prev_reg;
  assign root_fire = eic_mode && root_chg && (i_root_rpl > priority_mask_level);
  // a zero resident tag is the stop state; the guest bus is not trusted then
  assign guest_fire = eic_mode && vm_active_reg && guest_chg && (i_guest_rpl != '0)
                      && (resident_vm_tag_reg != '0) && !root_fire;
  assign inject_fire = inject_pend_reg && vm_active_reg && !root_fire;
  assign guest_entry = i_exception_return_op && vm_mode_select && !vm_active_reg;

  // a guest change blocked by root_fire is kept unseen so it is detected again
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      root_prev_reg <= '0;
      guest_prev_reg <= '0;
    end else begin
      if (eic_mode) begin
        root_prev_reg <= i_root_rpl;
      end
      if (!root_fire) begin
        guest_prev_reg <= i_guest_rpl;
      end
    end
  end

  // ************************************************************
  // mode and saved fields
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      vm_active_reg <= 1'b0;
    end else if (root_fire || i_monitor_call_op) begin
      vm_active_reg <= 1'b0;
    end else if (guest_entry) begin
      vm_active_reg <= 1'b1;
    end
  end
  assign o_vm_active = vm_active_reg;

  // hardware capture wins over a software write in the same cycle
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      interrupt_vm_tag_reg <= '0;
      saved_vm_priority_level_reg <= '0;
      saved_vm_shadow_set_reg <= '0;
      saved_vector_reg <= '0;
    end else if (root_fire && root_tagged) begin
      interrupt_vm_tag_reg <= i_root_vm_tag;
      saved_vm_priority_level_reg <= i_root_rpl;
      saved_vm_shadow_set_reg <= i_root_shadow_set;
      saved_vector_reg <= i_root_vector;
    end else if (guest_entry && saved_vm_priority_level_reg != '0) begin
      saved_vm_priority_level_reg <= '0;
    end else if (wr_do && aw_addr_reg == ADDR_SAVED) begin
      {saved_vector_reg, saved_vm_shadow_set_reg, saved_vm_priority_level_reg} <=
        {w_data_reg[SAV_VEC_LSB +: OFF_W], w_data_reg[SAV_SS_LSB +: SS_W],
         w_data_reg[SAV_LVL_LSB +: LVL_W]};
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      guest_req_lvl_reg <= '0;
      guest_ss_reg <= '0;
      inject_pend_reg <= 1'b0;
    end else if (guest_entry && saved_vm_priority_level_reg != '0) begin
      guest_req_lvl_reg <= saved_vm_priority_level_reg;
      guest_ss_reg <= saved_vm_shadow_set_reg;
      inject_pend_reg <= 1'b1;
    end else if (inject_fire) begin
      inject_pend_reg <= 1'b0;
    end else if (guest_fire) begin
      guest_ss_reg <= i_guest_shadow_set;
    end
  end

  // ************************************************************
  // interrupt outputs
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq_valid <= 1'b0;
      o_irq_guest_ctx <= 1'b0;
      o_vector_offset <= '0;
      o_shadow_set <= '0;
      o_root_ack <= 1'b0;
      o_guest_ack <= 1'b0;
    end else begin
      o_irq_valid <= root_fire || guest_fire || inject_fire;
      o_root_ack <= root_fire;
      o_guest_ack <= guest_fire;
      if (root_fire) begin
        o_irq_guest_ctx <= 1'b0;
        o_vector_offset <= vec_off(i_root_vector, root_tagged, vector_spacing);
        o_shadow_set <= root_tagged ? exception_shadow_set : i_root_shadow_set;
      end else if (inject_fire) begin
        o_irq_guest_ctx <= 1'b1;
        o_vector_offset <= vec_off(saved_vector_reg, 1'b0, vector_spacing);
        o_shadow_set <= guest_ss_reg;
      end else if (guest_fire) begin
        o_irq_guest_ctx <= 1'b1;
        o_vector_offset <= vec_off(i_guest_vector, 1'b0, vector_spacing);
        o_shadow_set <= i_guest_shadow_set;
      end
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  assign guest_read_lvl = (i_guest_rpl > guest_req_lvl_reg) ? i_guest_rpl
                          : guest_req_lvl_reg;

  always_comb begin
    rd_next = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (i_araddr)
      ADDR_CTRL: rd_next = ctrl_reg;
      ADDR_TAG: begin
        rd_next[TAG_RES_LSB +: TAG_W] = resident_vm_tag_reg;
        rd_next[TAG_EID_LSB +: TAG_W] = interrupt_vm_tag_reg;
      end
      ADDR_SAVED: begin
        rd_next[SAV_LVL_LSB +: LVL_W] = saved_vm_priority_level_reg;
        rd_next[SAV_SS_LSB +: SS_W] = saved_vm_shadow_set_reg;
        rd_next[SAV_VEC_LSB +: OFF_W] = saved_vector_reg;
      end
      ADDR_STAT: begin
        rd_next[STAT_LVL_LSB +: LVL_W] = eic_mode ? guest_read_lvl : '0;
        rd_next[STAT_SS_LSB +: SS_W] = guest_ss_reg;
        rd_next[STAT_ACT_BIT] = vm_active_reg;
        rd_next[STAT_EIC_BIT] = eic_mode;
        rd_next[STAT_VEC_LSB +: OFF_W] = o_vector_offset;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata <= rd_next;
      o_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_resetn);

  AST_MODE_GATE: assert property (o_irq_valid |-> $past(eic_mode))
    else $error("interrupt raised outside controller mode");
  AST_ROOT_ACK: assert property (o_root_ack == (o_irq_valid && !o_irq_guest_ctx))
    else $error("root ack does not match root interrupt");
  AST_NO_INJ_ACK: assert property ((inject_fire && !guest_fire) |=> !o_guest_ack)
    else $error("injected interrupt acked on guest bus");
  AST_ROOT_MASK: assert property ((o_irq_valid && !o_irq_guest_ctx)
    |-> ($past(i_root_rpl) > $past(priority_mask_level)) && $past(root_chg))
    else $error("root interrupt not above mask or without change");
  AST_GUEST_ROOTMODE: assert property (o_guest_ack |-> $past(vm_active_reg))
    else $error("guest bus taken in root mode");
  AST_ROOT_FIRST: assert property (root_fire |=> o_root_ack && !o_guest_ack)
    else $error("guest bus won over root bus");
  AST_VEC_TAGGED: assert property ((root_fire && root_tagged)
    |=> o_vector_offset == VEC_BASE && o_shadow_set == $past(exception_shadow_set))
    else $error("tagged root interrupt vector or set wrong");
  AST_EID: assert property ((root_fire && root_tagged)
    |=> interrupt_vm_tag_reg == $past(i_root_vm_tag))
    else $error("bus tag not recorded");
  AST_INJECT: assert property ((guest_entry && saved_vm_priority_level_reg != '0 && !root_fire)
    |=> guest_req_lvl_reg == $past(saved_vm_priority_level_reg) ##1
        (o_irq_valid && o_irq_guest_ctx) || !vm_active_reg)
    else $error("guest entry did not inject saved level");
  AST_TAG_LAG: assert property ($changed(o_resident_vm_tag) |-> $past(wr_do, 2))
    else $error("resident tag output changed without a write");

  COV_ROOT: cover property (o_irq_valid && !o_irq_guest_ctx);
  COV_GUEST: cover property (o_guest_ack);
  COV_INJECT: cover property (inject_fire);
  COV_TAGGED: cover property (root_fire && root_tagged);
endmodule
`default_nettype wire

// ===== tb/vei_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module vei_ctrl_model
  import vei_pkg::*;
(
  input wire logic [TAG_W-1:0] i_resident_vm_tag,
  output logic [LVL_W-1:0] o_root_rpl,
  output logic [OFF_W-1:0] o_root_vector,
  output logic [SS_W-1:0] o_root_shadow_set,
  output logic [TAG_W-1:0] o_root_vm_tag,
  output logic [LVL_W-1:0] o_guest_rpl,
  output logic [OFF_W-1:0] o_guest_vector,
  output logic [SS_W-1:0] o_guest_shadow_set
);
  // ************************************************************
  // separate requested levels per context
  // ************************************************************
  logic [LVL_W-1:0] guest_lvl;
  // zero resident tag is a stop: guest level held at zero
  assign o_guest_rpl = (i_resident_vm_tag == '0) ? '0 : guest_lvl;
  initial begin
    guest_lvl = '0;
    o_root_rpl = '0;
    o_root_vector = '0;
    o_root_shadow_set = '0;
    o_root_vm_tag = '0;
    o_guest_vector = '0;
    o_guest_shadow_set = '0;
  end
  // ************************************************************
  // bus postings, called just after a clock edge
  // ************************************************************
  // root bus takes root work, tagged work and non-resident guests
  task automatic post_root(input logic [LVL_W-1:0] l, input logic [OFF_W-1:0] v,
      input logic [SS_W-1:0] s, input logic [TAG_W-1:0] t);
    o_root_rpl <= l;
    o_root_vector <= v;
    o_root_shadow_set <= s;
    o_root_vm_tag <= t;
  endtask
  // guest bus carries the resident guest only, so no tag
  task automatic post_guest(input logic [LVL_W-1:0] l, input logic [OFF_W-1:0] v,
      input logic [SS_W-1:0] s);
    guest_lvl <= l;
    o_guest_vector <= v;
    o_guest_shadow_set <= s;
  endtask
endmodule
`default_nettype wire

// ===== tb/virtualized_ext_irq_iface_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module virtualized_ext_irq_iface_tb_top
  import vei_pkg::*;
;
  localparam logic [SS_W-1:0] EXCEPTION_SHADOW_SET = 4'h5;
  logic mclk, resetn, awvalid, wvalid, bready, arvalid, rready, exception_return_op;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awready, wready, bvalid, arready, rvalid, irq_valid, gctx, rack, gack, vm_active;
  logic [1:0] bresp, rresp;
  logic [OFF_W-1:0] voff, rvec, gvec;
  logic [SS_W-1:0] shd, rss, gss;
  logic [TAG_W-1:0] res_tag, rtag;
  logic [LVL_W-1:0] rrpl, grpl;
  logic [33:0] bus_q[$];
  logic [23:0] irq_q[$], msk_q[$];
  int mismatches, n_tests, seed;
  logic [4:0] vs;
  logic [5:0] num;
  logic [3:0] ss;

  vei_core uut (.i_mclk(mclk), .i_resetn(resetn), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
    .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_root_rpl(rrpl),
    .i_root_vector(rvec), .i_root_shadow_set(rss), .i_root_vm_tag(rtag),
    .i_guest_rpl(grpl), .i_guest_vector(gvec), .i_guest_shadow_set(gss),
    .i_exception_return_op(exception_return_op), .i_monitor_call_op(1'b0), .o_irq_valid(irq_valid),
    .o_irq_guest_ctx(gctx), .o_vector_offset(voff), .o_shadow_set(shd),
    .o_root_ack(rack), .o_guest_ack(gack), .o_resident_vm_tag(res_tag),
    .o_vm_active(vm_active));
  vei_ctrl_model ctl_m (.i_resident_vm_tag(res_tag), .o_root_rpl(rrpl), .o_root_vector(rvec),
    .o_root_shadow_set(rss), .o_root_vm_tag(rtag), .o_guest_rpl(grpl),
    .o_guest_vector(gvec), .o_guest_shadow_set(gss));

  always #12.5 mclk = ~mclk;
  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_irq(input logic [23:0] e, input logic [23:0] m, input logic [23:0] g);
    chk("irq", 34'(e), 34'(g & m));
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic timeout;
    mismatches++;
    $display("Error handshake expected answer seen none");
    end_of_test();
  endtask
  // results compared on the edge they are sampled at
  always @(posedge mclk) begin
    if (irq_valid === 1'b1) begin
      if (irq_q.size() == 0) chk("irq", 34'h0, 34'h1);
      else chk_irq(irq_q.pop_front(), msk_q.pop_front(), {gctx, rack, gack, shd, voff});
    end
    if (bvalid && bready) chk("bresp", bus_q.pop_front(), {bresp, 32'h0});
    if (rvalid && rready) chk("rdata", bus_q.pop_front(), {rresp, rdata});
  end
  // ************************************************************
  // bus tasks, entered just after a rising edge
  // ************************************************************
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic fin;
    n = 0;
    fin = 1'b0;
    bus_q.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!fin) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      fin = bready && bvalid;
      if (fin) bready <= 1'b0;
      n++;
      if (n > 50) timeout();
    end
    // one idle edge so a following call never re-raises ready in the same step
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d);
    int n;
    logic fin;
    n = 0;
    fin = 1'b0;
    bus_q.push_back({RESP_OKAY, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!fin) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      fin = rready && rvalid;
      if (fin) rready <= 1'b0;
      n++;
      if (n > 50) timeout();
    end
    @(posedge mclk);
  endtask
  task automatic note_irq(input logic [23:0] e, input logic [23:0] m);
    irq_q.push_back(e);
    msk_q.push_back(m);
  endtask
  // extra idle edges catch any interrupt nobody asked for
  task automatic settle;
    int n;
    n = 0;
    while (irq_q.size() != 0) begin
      @(posedge mclk);
      n++;
      if (n > 40) timeout();
    end
    repeat (6) @(posedge mclk);
  endtask
  function automatic logic [31:0] ctl(input logic [4:0] v, input logic [5:0] p, input logic g);
    ctl = {12'h0, EXCEPTION_SHADOW_SET, p, 1'b0, g, 1'b1, 1'b0, 1'b1, v};
  endfunction
  function automatic logic [16:0] voff_of(input logic [5:0] n, input logic [4:0] v);
    voff_of = VEC_BASE + 17'(n) * 17'({v, 5'h0});
  endfunction
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {mclk, resetn, awvalid, wvalid, bready, arvalid, rready, exception_return_op} = '0;
    {awaddr, araddr, wdata} = '0;
    seed = 32'h5D48;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd(ADDR_CTRL, RST_CTRL);
    wr(ADDR_STAT, 32'h1, RESP_SLVERR);
    wr(ADDR_CTRL, ctl(5'h1, 6'h0, 1'b0), RESP_OKAY);
    rd(ADDR_STAT, 32'h800);
    wr(ADDR_CTRL, ctl(5'h1, 6'h0, 1'b0) | 32'h40, RESP_OKAY);
    ctl_m.post_root(6'h2, 17'h4, 4'h3, 8'h0);
    settle();
    note_irq({3'b010, 4'h3, voff_of(6'h4, 5'h1)}, 24'hFFFFFF);
    wr(ADDR_CTRL, ctl(5'h1, 6'h0, 1'b0), RESP_OKAY);
    settle();
    for (int i = 0; i < 6; i++) begin
      vs = 5'({$random(seed)} % 31 + 1);
      num = 6'($random(seed));
      ss = 4'($random(seed));
      wr(ADDR_CTRL, ctl(vs, 6'h0, 1'b0), RESP_OKAY);
      note_irq({3'b010, ss, voff_of(num, vs)}, 24'hFFFFFF);
      ctl_m.post_root(6'(i + 3), 17'(num), ss, 8'h0);
      settle();
    end
    wr(ADDR_CTRL, ctl(5'h1, 6'h14, 1'b0), RESP_OKAY);
    ctl_m.post_root(6'h14, 17'h1, 4'h1, 8'h0);
    settle();
    note_irq({3'b010, 4'h3, voff_of(6'h2, 5'h1)}, 24'hFFFFFF);
    ctl_m.post_root(6'h15, 17'h2, 4'h3, 8'h0);
    settle();
    wr(ADDR_CTRL, ctl(5'h1, 6'h0, 1'b0), RESP_OKAY);
    note_irq({3'b010, EXCEPTION_SHADOW_SET, VEC_BASE}, 24'hFFFFFF);
    ctl_m.post_root(6'h9, 17'h5, 4'hA, 8'h7);
    settle();
    rd(ADDR_TAG, 32'h0700);
    note_irq({3'b010, 4'h2, voff_of(6'h1, 5'h1)}, 24'hFFFFFF);
    ctl_m.post_root(6'hC, 17'h1, 4'h2, 8'h0);
    settle();
    rd(ADDR_SAVED, {3'h0, 17'h5, 4'hA, 2'h0, 6'h9});
    wr(ADDR_TAG, 32'h3, RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk("resident_tag", 34'h3, 34'(res_tag));
    ctl_m.post_guest(6'h4, 17'h0, 4'h6);
    settle();
    wr(ADDR_CTRL, ctl(5'h1, 6'h0, 1'b1), RESP_OKAY);
    note_irq({3'b100, 4'hA, 17'h0}, 24'hFE0000);
    exception_return_op <= 1'b1;
    @(posedge mclk);
    exception_return_op <= 1'b0;
    settle();
    chk("vm_active", 34'h1, 34'(vm_active));
    rd(ADDR_SAVED, {3'h0, 17'h5, 4'hA, 2'h0, 6'h0});
    note_irq({3'b101, 4'h6, voff_of(6'h0, 5'h1)}, 24'hFFFFFF);
    ctl_m.post_guest(6'h7, 17'h0, 4'h6);
    settle();
    rd(ADDR_STAT, 32'h0020_0D89);
    note_irq({3'b010, 4'h1, voff_of(6'h3, 5'h1)}, 24'hFFFFFF);
    ctl_m.post_root(6'h1E, 17'h3, 4'h1, 8'h0);
    ctl_m.post_guest(6'h8, 17'h0, 4'h6);
    settle();
    wr(ADDR_TAG, 32'h0, RESP_OKAY);
    repeat (2) @(posedge mclk);
    chk("resident_tag", 34'h0, 34'(res_tag));
    end_of_test();
  end
endmodule
`default_nettype wire
